// [hdl/ack_bus_pkg.sv]
`default_nettype none
package ack_bus_pkg;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NSRC = 4;
  localparam int unsigned SRC_W = 2;
  localparam int unsigned CNT_W = 8;
  // Internal priority settle time, a least time.
  localparam int unsigned SETTLE_INT_NS = 250;
  localparam int unsigned SETTLE_INT_CYC = (SETTLE_INT_NS + CLK_NS - 1) / CLK_NS;
  // Extra settle time for each chained device.
  localparam int unsigned SETTLE_DEV_NS = 160;
  localparam int unsigned SETTLE_DEV_CYC = (SETTLE_DEV_NS + CLK_NS - 1) / CLK_NS;
  // Least spacing between strobe falls of two accesses.
  localparam int unsigned RECOVERY_CYC = 4;
  // Strobe and hold lengths cover the two-stage synchroniser and edge detect.
  localparam int unsigned STROBE_CYC = 6;
  localparam int unsigned HOLD_CYC = 3;
  localparam int unsigned ADDR_CYC = 6;
  localparam int unsigned SEP_SETUP_CYC = 3;
  localparam int unsigned PLAIN_SETTLE_CYC = 2;
  localparam int unsigned IDLE_AS_CYC = 16;
  localparam logic BUS_MUX = 1'b0;
  localparam logic BUS_SEP = 1'b1;
  localparam int unsigned DEV_SYNC_W = 20;
  localparam logic [DEV_SYNC_W-1:0] DEV_SYNC_INIT = 20'hFB8FF;
  localparam logic [DATA_W-1:0] DOUT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;
  typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_ACK} cmd_e;
endpackage
`default_nettype wire

// [hdl/ack_bus_if.sv]
`default_nettype none
interface ack_bus_if;
  import ack_bus_pkg::*;
  logic              as_n;
  logic              data_strobe_n;
  logic              rw;
  logic              ack_n;
  logic              sel_l_n;
  logic              sel_lvl;
  logic              rd_n;
  logic              wr_n;
  logic              ce_n;
  logic              chan_sel;
  logic              dc_sel;
  logic              daisy_enable_in;
  logic              daisy_enable_out;
  logic              int_n;
  logic [DATA_W-1:0] host_d;
  logic              host_d_oe;
  logic [DATA_W-1:0] dev_d;
  logic              dev_d_oe;
  logic [DATA_W-1:0] bus_d;
  // Resolved data lines; a floating bus reads as pulled high.
  assign bus_d = dev_d_oe ? dev_d : (host_d_oe ? host_d : BUS_IDLE);
  modport dev (input as_n, data_strobe_n, rw, ack_n, sel_l_n, sel_lvl, rd_n, wr_n,
               ce_n, chan_sel, dc_sel, daisy_enable_in, bus_d,
               output dev_d, dev_d_oe, int_n, daisy_enable_out);
  modport host (output as_n, data_strobe_n, rw, ack_n, sel_l_n, sel_lvl, rd_n, wr_n,
                ce_n, chan_sel, dc_sel, daisy_enable_in, host_d, host_d_oe,
                input bus_d, int_n, daisy_enable_out);
endinterface
`default_nettype wire

// [hdl/bus_sync.sv]
`default_nettype none
module bus_sync #(
  parameter int unsigned   W    = 1,
  parameter logic [W-1:0]  INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= INIT;
      q       <= INIT;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// [hdl/ack_bus_device.sv]
`default_nettype none
// What this block does
// - Latch acknowledge, select, address on strobe rise.
// - Acknowledge cycle ignores address, selects, direction.
// - Host waits for chains between strobes.
// - Own acknowledge sets in-service, drives vector.
// - Suppress bit stops vector drive.
// - Interrupt output drops on accepted acknowledge.
// - Host gives one data strobe per acknowledge.
// - Pending bits update only on address strobe on the multiplexed bus; each clock on the separate bus.
// - Host spaces strobe falls four clocks apart.
// - Spacing counts only this device's accesses.
// - Host holds selects stable through cycle.
// - Host raises write strobe before address drops.
// - Write data taken at strobe end.
// - Host waits for chains before read strobe.
// - Separate bus acknowledge may drive vector.
// - Separate bus acknowledge sets in-service latch.
// - Settle time grows with chained devices.
module ack_bus_device
  import ack_bus_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              RSTN,
  ack_bus_if.dev                 BUS,
  input  wire logic              BUS_MODE,
  input  wire logic [NSRC-1:0]   SRC_REQ,
  input  wire logic              VEC_SUPPRESS,
  input  wire logic [DATA_W-1:0] VEC_BASE,
  input  wire logic              SVC_CLEAR,
  input  wire logic [DATA_W-1:0] REG_RDATA,
  output logic                   REG_RD,
  output logic                   REG_WR,
  output logic      [DATA_W-1:0] REG_ADDR,
  output logic      [DATA_W-1:0] REG_WDATA,
  output logic      [NSRC-1:0]   PENDING,
  output logic      [NSRC-1:0]   IN_SERVICE,
  output logic                   ACK_TAKEN
);
  logic [DEV_SYNC_W-1:0] raw;
  logic [DEV_SYNC_W-1:0] s;
  logic                  s_as_n;
  logic                  s_dstb_n;
  logic                  s_rw;
  logic                  s_ack_n;
  logic                  s_sel_l_n;
  logic                  s_sel_lvl;
  logic                  s_rd_n;
  logic                  s_wr_n;
  logic                  s_ce_n;
  logic                  s_chain_in;
  logic [DATA_W-1:0]     s_d;
  logic                  rd_eff;
  logic                  wr_eff;
  logic                  rd_ack;
  logic                  as_prev_ff;
  logic                  dstb_prev_ff;
  logic                  rd_eff_prev_ff;
  logic                  wr_eff_prev_ff;
  logic                  rd_ack_prev_ff;
  logic                  as_rise;
  logic                  dstb_fall;
  logic                  dstb_rise;
  logic                  ack_lat_ff;
  logic                  sel_lat_ff;
  logic [DATA_W-1:0]     addr_lat_ff;
  logic                  mux_acc;
  logic                  ack_fall;
  logic                  acc_rd;
  logic                  acc_wr;
  logic                  strobe_low;
  logic                  ack_phase;
  logic [NSRC-1:0]       pend_ff;
  logic [NSRC-1:0]       svc_ff;
  logic [NSRC-1:0]       avail;
  logic [NSRC-1:0]       set_oh;
  logic [NSRC-1:0]       clr_oh;
  logic [SRC_W-1:0]      sel_idx;
  logic                  ack_go;
  logic                  int_n_ff;
  logic [DATA_W-1:0]     dout_ff;
  logic                  oe_ff;
  logic [DATA_W-1:0]     acc_addr;

  assign raw = {BUS.as_n, BUS.data_strobe_n, BUS.rw, BUS.ack_n, BUS.sel_l_n, BUS.sel_lvl,
                BUS.rd_n, BUS.wr_n, BUS.ce_n, BUS.chan_sel, BUS.dc_sel, BUS.daisy_enable_in,
                BUS.bus_d};

  bus_sync #(
    .W    (DEV_SYNC_W),
    .INIT (DEV_SYNC_INIT)
  ) u_sync (
    .clk  (CORE_CLK),
    .rstn (RSTN),
    .d    (raw),
    .q    (s)
  );

  assign {s_as_n, s_dstb_n, s_rw, s_ack_n, s_sel_l_n, s_sel_lvl} = s[19:14];
  assign {s_rd_n, s_wr_n, s_ce_n} = s[13:11];
  assign s_chain_in = s[8];
  assign s_d = s[7:0];

  // An acknowledge needs no chip enable, so it has a strobe of its own.
  assign rd_eff = ~s_rd_n & ~s_ce_n & s_ack_n;
  assign wr_eff = ~s_wr_n & ~s_ce_n & s_ack_n;
  assign rd_ack = ~s_rd_n & ~s_ack_n;

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      as_prev_ff     <= 1'b1;
      dstb_prev_ff   <= 1'b1;
      rd_eff_prev_ff <= 1'b0;
      wr_eff_prev_ff <= 1'b0;
      rd_ack_prev_ff <= 1'b0;
    end
    else
    begin
      as_prev_ff     <= s_as_n;
      dstb_prev_ff   <= s_dstb_n;
      rd_eff_prev_ff <= rd_eff;
      wr_eff_prev_ff <= wr_eff;
      rd_ack_prev_ff <= rd_ack;
    end
  end

  assign as_rise = s_as_n & ~as_prev_ff;
  assign dstb_fall = ~s_dstb_n & dstb_prev_ff;
  assign dstb_rise = s_dstb_n & ~dstb_prev_ff;

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ack_lat_ff  <= 1'b0;
      sel_lat_ff  <= 1'b0;
      addr_lat_ff <= DOUT_RESET;
    end
    else if (as_rise && BUS_MODE == BUS_MUX)
    begin
      ack_lat_ff  <= ~s_ack_n;
      sel_lat_ff  <= ~s_sel_l_n;
      addr_lat_ff <= s_d;
    end
  end

  // Address, both selects and direction matter only outside acknowledges.
  assign mux_acc = ~ack_lat_ff & sel_lat_ff & s_sel_lvl;

  always_comb
  begin
    if (BUS_MODE == BUS_MUX)
    begin
      ack_fall   = dstb_fall & ack_lat_ff;
      acc_rd     = dstb_fall & s_rw & mux_acc;
      acc_wr     = dstb_rise & ~s_rw & mux_acc;
      strobe_low = ~s_dstb_n;
      ack_phase  = ack_lat_ff;
      acc_addr   = addr_lat_ff;
    end
    else
    begin
      ack_fall   = rd_ack & ~rd_ack_prev_ff;
      acc_rd     = rd_eff & ~rd_eff_prev_ff;
      acc_wr     = ~wr_eff & wr_eff_prev_ff;
      strobe_low = rd_eff | rd_ack;
      ack_phase  = ~s_ack_n;
      acc_addr   = {{(DATA_W-2){1'b0}}, s[10], s[9]};
    end
  end

  // Pending bits follow the sources only at address strobe rises on the
  // multiplexed bus; the separate bus has no such strobe and samples each clock.
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pend_ff <= '0;
    end
    else if (BUS_MODE == BUS_SEP || as_rise)
    begin
      pend_ff <= SRC_REQ;
    end
  end

  // Lower index is higher priority; a source in service blocks itself and all
  // higher-index ones.
  always_comb
  begin
    logic blocked;
    logic found;
    logic cfound;
    blocked = 1'b0;
    found   = 1'b0;
    cfound  = 1'b0;
    avail   = '0;
    clr_oh  = '0;
    sel_idx = '0;
    for (int i = 0; i < NSRC; i++)
    begin
      blocked  = blocked | svc_ff[i];
      avail[i] = pend_ff[i] & ~blocked;
      if (avail[i] && !found)
      begin
        sel_idx = SRC_W'(i);
        found   = 1'b1;
      end
      if (svc_ff[i] && !cfound)
      begin
        clr_oh[i] = SVC_CLEAR;
        cfound    = 1'b1;
      end
    end
  end

  assign ack_go = ack_fall & (|avail) & s_chain_in;
  assign set_oh = ack_go ? (NSRC'(1) << sel_idx) : '0;

  // A set in the same cycle as a clear wins.
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      svc_ff <= '0;
    end
    else
    begin
      svc_ff <= (svc_ff & ~clr_oh) | set_oh;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      int_n_ff <= 1'b1;
    end
    else
    begin
      int_n_ff <= ack_go | ~(|avail);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      dout_ff <= DOUT_RESET;
      oe_ff   <= 1'b0;
    end
    else if (ack_go)
    begin
      dout_ff <= {VEC_BASE[DATA_W-1:SRC_W], sel_idx};
      oe_ff   <= ~VEC_SUPPRESS;
    end
    else if (acc_rd)
    begin
      dout_ff <= REG_RDATA;
      oe_ff   <= 1'b1;
    end
    else if (!strobe_low)
    begin
      oe_ff <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      REG_ADDR  <= DOUT_RESET;
      REG_WDATA <= DOUT_RESET;
    end
    else if (acc_rd || acc_wr)
    begin
      REG_ADDR  <= acc_addr;
      REG_WDATA <= s_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      REG_RD    <= 1'b0;
      REG_WR    <= 1'b0;
      ACK_TAKEN <= 1'b0;
    end
    else
    begin
      REG_RD    <= acc_rd;
      REG_WR    <= acc_wr;
      ACK_TAKEN <= ack_go;
    end
  end

  assign BUS.dev_d    = dout_ff;
  assign BUS.dev_d_oe = oe_ff;
  assign BUS.int_n    = int_n_ff;
  assign BUS.daisy_enable_out = s_chain_in & ~(|svc_ff) & ~(ack_phase & (|pend_ff));
  assign PENDING      = pend_ff;
  assign IN_SERVICE   = svc_ff;
endmodule
`default_nettype wire

// [hdl/ack_bus_host.sv]
`default_nettype none
module ack_bus_host
  import ack_bus_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              RSTN,
  ack_bus_if.host                BUS,
  input  wire logic              BUS_MODE,
  input  wire logic [3:0]        CHAIN_DEVICES,
  input  wire logic              CMD_VALID,
  input  wire cmd_e              CMD_KIND,
  input  wire logic [DATA_W-1:0] CMD_ADDR,
  input  wire logic [DATA_W-1:0] CMD_WDATA,
  output logic                   CMD_READY,
  output logic                   RSP_VALID,
  output logic      [DATA_W-1:0] RSP_DATA,
  output logic                   IRQ
);
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_SETTLE, H_STROBE, H_RELEASE,
                            H_PING} state_e;
  state_e            state_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  gap_ff;
  logic [CNT_W-1:0]  settle_cyc;
  cmd_e              kind_ff;
  logic [DATA_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic              is_ack;
  logic              is_wr;
  logic              mux;
  logic              strobe;
  logic              irq_meta_ff;
  logic              cnt_done;

  assign is_ack   = kind_ff == CMD_ACK;
  assign is_wr    = kind_ff == CMD_WRITE;
  assign mux      = BUS_MODE == BUS_MUX;
  assign cnt_done = cnt_ff == '0;
  assign settle_cyc = is_ack ? CNT_W'(SETTLE_INT_CYC + CHAIN_DEVICES * SETTLE_DEV_CYC)
                             : CNT_W'(PLAIN_SETTLE_CYC);

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_ff <= H_IDLE;
      cnt_ff   <= '0;
      kind_ff  <= CMD_READ;
      addr_ff  <= '0;
      wdata_ff <= '0;
    end
    else
    begin
      unique case (state_ff)
        H_IDLE:
        begin
          if (CMD_VALID)
          begin
            state_ff <= H_ADDR;
            cnt_ff   <= CNT_W'(mux ? ADDR_CYC : SEP_SETUP_CYC);
            kind_ff  <= CMD_KIND;
            addr_ff  <= CMD_ADDR;
            wdata_ff <= CMD_WDATA;
          end
          else if (mux && gap_ff >= CNT_W'(IDLE_AS_CYC))
          begin
            state_ff <= H_PING;
            cnt_ff   <= CNT_W'(ADDR_CYC);
          end
        end
        H_ADDR:
        begin
          cnt_ff <= cnt_ff - CNT_W'(1);
          if (cnt_done)
          begin
            state_ff <= H_SETTLE;
            cnt_ff   <= settle_cyc;
          end
        end
        H_SETTLE:
        begin
          if (!cnt_done)
          begin
            cnt_ff <= cnt_ff - CNT_W'(1);
          end
          else if (gap_ff >= CNT_W'(RECOVERY_CYC))
          begin
            state_ff <= H_STROBE;
            cnt_ff   <= CNT_W'(STROBE_CYC);
          end
        end
        H_STROBE:
        begin
          cnt_ff <= cnt_ff - CNT_W'(1);
          if (cnt_done)
          begin
            state_ff <= H_RELEASE;
            cnt_ff   <= CNT_W'(HOLD_CYC);
          end
        end
        H_RELEASE, H_PING:
        begin
          cnt_ff <= cnt_ff - CNT_W'(1);
          if (cnt_done)
          begin
            state_ff <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Counts clocks since the last strobe fall of an access to the device;
  // address strobe pings carry no select and load it with RECOVERY_CYC instead of zero.
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      gap_ff <= CNT_W'(IDLE_AS_CYC);
    end
    else if (state_ff == H_SETTLE && cnt_done && gap_ff >= CNT_W'(RECOVERY_CYC))
    begin
      gap_ff <= '0;
    end
    else if (state_ff == H_PING)
    begin
      gap_ff <= CNT_W'(RECOVERY_CYC);
    end
    else if (gap_ff != CNT_W'(IDLE_AS_CYC))
    begin
      gap_ff <= gap_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      RSP_VALID <= 1'b0;
      RSP_DATA  <= '0;
    end
    else
    begin
      RSP_VALID <= state_ff == H_STROBE && cnt_done && !is_wr;
      if (state_ff == H_STROBE && cnt_done)
      begin
        RSP_DATA <= BUS.bus_d;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      irq_meta_ff <= 1'b0;
      IRQ         <= 1'b0;
    end
    else
    begin
      irq_meta_ff <= ~BUS.int_n;
      IRQ         <= irq_meta_ff;
    end
  end

  // Level select, chip enable, direction and acknowledge hold from setup through release.
  assign strobe        = state_ff == H_STROBE;
  assign CMD_READY     = state_ff == H_IDLE;
  assign BUS.as_n      = ~(mux && (state_ff == H_ADDR || state_ff == H_PING));
  assign BUS.data_strobe_n = ~(mux && strobe);
  assign BUS.rd_n      = ~(!mux && strobe && !is_wr);
  assign BUS.wr_n      = ~(!mux && strobe && is_wr);
  assign BUS.ce_n      = ~(!mux && !is_ack && state_ff inside {H_ADDR, H_SETTLE, H_STROBE,
                           H_RELEASE});
  assign BUS.ack_n     = ~(is_ack && state_ff inside {H_ADDR, H_SETTLE, H_STROBE,
                           H_RELEASE});
  // Address and latched select hold through the settle time, so that the
  // device's synchronised view of the address strobe rise still sees them.
  assign BUS.sel_l_n   = ~(mux && !is_ack && state_ff inside {H_ADDR, H_SETTLE});
  assign BUS.sel_lvl   = mux && !is_ack && state_ff != H_IDLE && state_ff != H_PING;
  assign BUS.rw        = !is_wr;
  assign BUS.chan_sel  = addr_ff[1];
  assign BUS.dc_sel    = addr_ff[0];
  assign BUS.daisy_enable_in = 1'b1;
  assign BUS.host_d    = (state_ff inside {H_ADDR, H_SETTLE}) ? addr_ff : wdata_ff;
  assign BUS.host_d_oe = (mux && state_ff inside {H_ADDR, H_SETTLE})
                       || (is_wr && state_ff inside {H_STROBE, H_RELEASE});
endmodule
`default_nettype wire

// [verif/ack_bus_sva.sv]
`default_nettype none
module ack_bus_sva
  import ack_bus_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic as_n,
  input wire logic dstb_n,
  input wire logic ack_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ce_n,
  input wire logic chan_sel,
  input wire logic dc_sel,
  input wire logic int_n,
  input wire logic dev_d_oe
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  logic [CNT_W-1:0] gap_ff;
  logic [CNT_W-1:0] settle_ff;
  logic [1:0]       ds_cnt_ff;

  // Cycles since the last strobe fall of any access.
  always_ff @(posedge CORE_CLK or negedge RSTN)
    if (!RSTN)
      gap_ff <= '1;
    else if ($fell(dstb_n) || $fell(rd_n) || $fell(wr_n))
      gap_ff <= '0;
    else if (gap_ff != '1)
      gap_ff <= gap_ff + 1'b1;

  // Cycles since the acknowledge phase started its settle window.
  always_ff @(posedge CORE_CLK or negedge RSTN)
    if (!RSTN)
      settle_ff <= '0;
    else if ($rose(as_n) || $fell(ack_n))
      settle_ff <= '0;
    else if (settle_ff != '1)
      settle_ff <= settle_ff + 1'b1;

  // Data strobes seen inside one acknowledge cycle.
  always_ff @(posedge CORE_CLK or negedge RSTN)
    if (!RSTN)
      ds_cnt_ff <= '0;
    else if (ack_n)
      ds_cnt_ff <= '0;
    else if ($fell(dstb_n) && ds_cnt_ff != 2'h3)
      ds_cnt_ff <= ds_cnt_ff + 1'b1;

  chk_strobe_gap_min: assert property (($fell(dstb_n) || $fell(rd_n) || $fell(wr_n))
    |-> gap_ff >= RECOVERY_CYC - 1) else $error("strobe falls too close together");
  chk_one_data_strobe: assert property (ds_cnt_ff <= 2'h1)
    else $error("more than one data strobe in acknowledge");
  chk_chain_settle: assert property ((($fell(dstb_n) || $fell(rd_n)) && !ack_n)
    |-> settle_ff >= SETTLE_INT_CYC - 1) else $error("acknowledge strobe before settle");
  chk_vector_in_strobe: assert property ($rose(dev_d_oe) |-> (!dstb_n || !rd_n))
    else $error("data driven outside a strobe");
  chk_irq_drop: assert property (($rose(dev_d_oe) && !ack_n) |-> ##[0:1] int_n)
    else $error("interrupt still active after acknowledge");
  chk_ce_gate: assert property (($rose(dev_d_oe) && ack_n && dstb_n) |-> !ce_n && !rd_n)
    else $error("read data driven without chip enable");
  chk_oe_release: assert property ($rose(dstb_n && rd_n) |-> ##[0:5] !dev_d_oe)
    else $error("data drive held after strobe");
  chk_sep_stable: assert property ((!(rd_n && wr_n) && $past(!(rd_n && wr_n)))
    |-> $stable({chan_sel, dc_sel, ack_n})) else $error("selects moved in cycle");
  chk_wr_release: assert property ($rose(wr_n) |=> $stable({chan_sel, dc_sel}))
    else $error("address dropped with write strobe");

  cover property ($rose(dev_d_oe) && !ack_n && !dstb_n);
  cover property ($rose(dev_d_oe) && !ack_n && !rd_n);
  cover property ($rose(wr_n));
endmodule
`default_nettype wire

// [verif/interrupt_ack_bus_cycle_tb_top.sv]
`default_nettype none
module interrupt_ack_bus_cycle_tb_top
  import ack_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              core_clk;
  logic              rstn;
  logic              mode;
  logic [3:0]        chain_devices;
  logic              cmd_valid;
  cmd_e              cmd_kind;
  logic [DATA_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata;
  logic              cmd_ready;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  logic              irq;
  logic [NSRC-1:0]   src_req;
  logic              vec_suppress;
  logic [DATA_W-1:0] vec_base;
  logic              svc_clear;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_rd;
  logic              reg_wr;
  logic [DATA_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [NSRC-1:0]   pending;
  logic [NSRC-1:0]   in_service;
  logic              ack_taken;
  logic [DATA_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_addr;
  logic [DATA_W-1:0] rsp;
  int                acks;
  int                err_count;
  int                total_checks;

  ack_bus_if bus_if ();

  ack_bus_device i_ack_bus_device (.CORE_CLK(core_clk), .RSTN(rstn), .BUS(bus_if),
    .BUS_MODE(mode), .SRC_REQ(src_req), .VEC_SUPPRESS(vec_suppress), .VEC_BASE(vec_base),
    .SVC_CLEAR(svc_clear), .REG_RDATA(reg_rdata), .REG_RD(reg_rd), .REG_WR(reg_wr),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .PENDING(pending),
    .IN_SERVICE(in_service), .ACK_TAKEN(ack_taken));

  ack_bus_host i_ack_bus_host (.CORE_CLK(core_clk), .RSTN(rstn), .BUS(bus_if),
    .BUS_MODE(mode), .CHAIN_DEVICES(chain_devices), .CMD_VALID(cmd_valid),
    .CMD_KIND(cmd_kind), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .IRQ(irq));

  ack_bus_sva i_ack_bus_sva (.CORE_CLK(core_clk), .RSTN(rstn), .as_n(bus_if.as_n),
    .dstb_n(bus_if.data_strobe_n), .ack_n(bus_if.ack_n), .rd_n(bus_if.rd_n),
    .wr_n(bus_if.wr_n),
    .ce_n(bus_if.ce_n), .chan_sel(bus_if.chan_sel), .dc_sel(bus_if.dc_sel),
    .int_n(bus_if.int_n), .dev_d_oe(bus_if.dev_d_oe));

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk)
    if (reg_wr === 1'b1)
      {wr_addr, wr_data} <= {reg_addr, reg_wdata};
  always @(posedge core_clk)
    if (reg_rd === 1'b1)
      rd_addr <= reg_addr;
  always @(posedge core_clk)
    if (ack_taken === 1'b1)
      acks <= acks + 1;

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic give_up;
    err_count++;
    wrap_up();
  endtask

  task automatic do_reset(input logic m);
    rstn = 1'b0;
    mode = m;
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
  endtask

  // Holds the request until the host takes it, then waits for idle and, unless it is a write, its answer.
  task automatic run_cmd(input cmd_e k, input logic [DATA_W-1:0] a,
                         input logic [DATA_W-1:0] w);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_wdata = w;
    while (cmd_ready !== 1'b1)
    begin
      n++;
      if (n > 300)
        give_up();
      @(negedge core_clk);
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (!(cmd_ready === 1'b1 && (got || k == CMD_WRITE)))
    begin
      if (rsp_valid === 1'b1)
        rsp = rsp_data;
      got = got || (rsp_valid === 1'b1);
      n++;
      if (n > 300)
        give_up();
      @(negedge core_clk);
    end
    repeat (6) @(negedge core_clk);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1)
    begin
      n++;
      if (n > 400)
        give_up();
      @(negedge core_clk);
    end
  endtask

  initial
  begin
    core_clk = 1'b0;
    rstn = 1'b0;
    mode = BUS_MUX;
    chain_devices = 4'h1;
    cmd_valid = 1'b0;
    cmd_kind = CMD_READ;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    src_req = 4'h0;
    vec_suppress = 1'b0;
    vec_base = 8'hA0;
    svc_clear = 1'b0;
    reg_rdata = 8'h5A;
    acks = 0;
    err_count = 0;
    total_checks = 0;
    do_reset(BUS_MUX);
    run_cmd(CMD_WRITE, 8'h3C, 8'hA5);
    check(wr_addr, 8'h3C);
    check(wr_data, 8'hA5);
    run_cmd(CMD_READ, 8'h11, 8'h00);
    check(rsp, 8'h5A);
    check(rd_addr, 8'h11);
    run_cmd(CMD_ACK, 8'h3C, 8'h00);
    check(rsp, BUS_IDLE);
    check(DATA_W'(acks), 8'h00);
    src_req = 4'h6;
    wait_irq();
    check({4'h0, pending}, 8'h06);
    run_cmd(CMD_ACK, 8'hFF, 8'h00);
    check(rd_addr, 8'h11);
    check(rsp, 8'hA1);
    check({4'h0, in_service}, 8'h02);
    check({7'h00, irq}, 8'h00);
    check({7'h00, bus_if.daisy_enable_out}, 8'h00);
    @(negedge core_clk);
    svc_clear = 1'b1;
    @(negedge core_clk);
    svc_clear = 1'b0;
    wait_irq();
    vec_suppress = 1'b1;
    run_cmd(CMD_ACK, 8'h00, 8'h00);
    check(rsp, BUS_IDLE);
    check({4'h0, in_service}, 8'h02);
    vec_suppress = 1'b0;
    src_req = 4'h0;
    do_reset(BUS_SEP);
    reg_rdata = 8'hC3;
    run_cmd(CMD_WRITE, 8'h03, 8'h96);
    check(wr_addr, 8'h03);
    check(wr_data, 8'h96);
    run_cmd(CMD_READ, 8'h02, 8'h00);
    check(rsp, 8'hC3);
    check(rd_addr, 8'h02);
    src_req = 4'h8;
    wait_irq();
    run_cmd(CMD_ACK, 8'h00, 8'h00);
    check(rsp, 8'hA3);
    check({4'h0, in_service}, 8'h08);
    wrap_up();
  end
endmodule
`default_nettype wire
